// ==== design/rbm_params.svh ====
// constants for the record biquad, mixer and decimation block
`ifndef RBM_PARAMS_SVH
`define RBM_PARAMS_SVH
// control port pages
`define RBM_PAGE_CFG       8'h00
`define RBM_PAGE_BQ_LO     8'h08
`define RBM_PAGE_BQ_HI     8'h09
`define RBM_PAGE_MIX       8'h0C
// page 0 register offsets
`define RBM_REG_DSP_CFG    7'h72
`define RBM_REG_LP_CFG     7'h4E
`define RBM_REG_CTRL       7'h73
`define RBM_REG_STATUS     7'h74
// reset values
`define RBM_DSP_CFG_RST    8'h08
`define RBM_LP_CFG_RST     8'h00
`define RBM_CTRL_RST       8'h00
// field positions
`define RBM_DECI_HI        7
`define RBM_DECI_LO        6
`define RBM_BQ_HI          3
`define RBM_BQ_LO          2
`define RBM_LP_BIT         2
`define RBM_CTRL_BANK      0
`define RBM_CTRL_TWO_CH    1
`define RBM_CTRL_SUM       2
`define RBM_CTRL_PDM_LO    4
`define RBM_STAT_BUSY      0
`define RBM_STAT_OVERRUN   1
`define RBM_STAT_BANK      2
// coefficient storage layout
`define RBM_BQ_BASE        7'h08
`define RBM_BQ_BYTES       20
`define RBM_BQ_NUM         12
`define RBM_BQ_PAGE_BYTES  8'd120
`define RBM_BQ_TOTAL       240
`define RBM_BANK_OFFSET    4'd2
`define RBM_MIX_BASE       7'h08
`define RBM_MIX_END        7'h48
`define RBM_MIX_TOTAL      64
// fractional arithmetic
`define RBM_COEF_ONE       32'h7FFFFFFF
`define RBM_COEF_QUARTER   32'h20000000
`define RBM_FRAC_SHIFT     31
`define RBM_FRAC_ROUND     64'sh40000000
`define RBM_PDM_POS        8'h7F
`define RBM_PDM_NEG        8'h81
// widths and depths
`define RBM_NUM_CH         4
`define RBM_SAMPLE_W       24
`define RBM_FIFO_DEPTH     4
`endif

// ==== design/rbm_pkg.sv ====
// types shared by the record biquad, mixer and decimation block
package rbm_pkg;
  // engine sequencing
  typedef enum logic [1:0] {
    RBM_ST_IDLE = 2'b00,
    RBM_ST_MIX  = 2'b01,
    RBM_ST_BQ   = 2'b10,
    RBM_ST_PUSH = 2'b11
  } rbm_state_t;
  // decimation filter type field
  typedef enum logic [1:0] {
    RBM_DECI_LINEAR = 2'b00,
    RBM_DECI_LOW    = 2'b01,
    RBM_DECI_ULTRA  = 2'b10,
    RBM_DECI_RSVD   = 2'b11
  } rbm_deci_t;
  // one output sample tagged with its channel
  typedef struct packed {
    logic [1:0]         ch;
    logic signed [23:0] data;
  } rbm_sample_t;
  // oversampled modulator and microphone input
  typedef struct packed {
    logic        valid;
    logic [3:0]  pdm;
    logic [31:0] multibit;
  } rbm_mod_in_t;
  // control port byte access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] page;
    logic [6:0] addr;
    logic [7:0] wdata;
  } rbm_ctl_req_t;
endpackage

// ==== design/rbm_fifo.sv ====
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/100ps
module rbm_fifo #(
  parameter int WIDTH = 26,  // word width
  parameter int DEPTH = 4    // number of words
) (
  input  wire logic             clk,        // core clock
  input  wire logic             reset_n,    // synchronous reset, active low
  input  wire logic             in_valid,   // word offered
  input  wire logic [WIDTH-1:0] in_data,    // word in
  output logic                  in_ready,   // room for a word
  output logic                  out_valid,  // word available
  output logic [WIDTH-1:0]      out_data,   // head word
  input  wire logic             out_ready,  // head consumed
  output logic [$clog2(DEPTH):0] level      // words held
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];  // storage
  logic [AW-1:0]    wr_ptr_q;       // write index
  logic [AW-1:0]    rd_ptr_q;       // read index
  logic [AW:0]      count_q;        // fill level
  logic             push;           // accepted write
  logic             pop;            // accepted read

  assign in_ready  = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data  = mem_q[rd_ptr_q];
  assign level     = count_q;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // pointers and level
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ==== design/rbm_record_dsp.sv ====
// record path: decimation, channel mixer, biquad cascade, output fifo
`timescale 1ns/100ps
`include "rbm_params.svh"
module rbm_record_dsp (
  input  wire logic                 clk,          // 40 MHz core clock
  input  wire logic                 reset_n,      // synchronous reset, active low
  input  wire rbm_pkg::rbm_ctl_req_t ctl,         // control port byte request
  output logic [7:0]                ctl_rdata,    // control port read byte
  input  wire rbm_pkg::rbm_mod_in_t mod_in,       // oversampled channel input
  input  wire logic                 frame_sync,   // one pulse per output frame
  output logic                      out_valid,    // output sample present
  output rbm_pkg::rbm_sample_t      out_sample,   // output sample and channel
  input  wire logic                 out_ready     // downstream takes sample
);
  localparam int SW = `RBM_SAMPLE_W;

  // configuration registers
  logic [7:0] dsp_cfg_q;                          // decimation type, allocation
  logic [7:0] lp_cfg_q;                           // low-power filter bit
  logic [7:0] ctrl_q;                             // bank, two-channel, sum, pdm
  logic       overrun_q;                          // frame arrived while busy
  logic [7:0] ctl_rdata_q;                        // read data register
  logic [7:0] bq_mem_q  [`RBM_BQ_TOTAL];          // biquad coefficient bytes
  logic [7:0] mix_mem_q [`RBM_MIX_TOTAL];         // mixer coefficient bytes

  // field views
  logic [1:0] alloc;                              // biquads per channel
  rbm_pkg::rbm_deci_t deci_type;                  // decimation type
  logic       low_power;                          // low-power decimation
  logic       bank_sel;                           // second bank selected
  logic       two_ch;                             // two-channel record mode
  logic       sum_mode;                           // equal-weight summing
  logic [3:0] pdm_sel;                            // per-channel microphone input

  // address decode
  logic       bq_hit;                             // biquad coefficient page
  logic       mix_hit;                            // mixer coefficient page
  logic [7:0] bq_idx;                             // byte index into biquad store
  logic [5:0] mix_idx;                            // byte index into mixer store

  // datapath
  logic signed [31:0] acc_q  [`RBM_NUM_CH];       // decimation accumulators
  logic signed [31:0] prev_q [`RBM_NUM_CH];       // previous frame accumulation
  logic signed [SW-1:0] dec_q  [`RBM_NUM_CH];     // decimated samples
  logic signed [SW-1:0] chan_q [`RBM_NUM_CH];     // working channel samples
  logic signed [SW-1:0] bq_x1_q [`RBM_BQ_NUM];    // input delay one
  logic signed [SW-1:0] bq_x2_q [`RBM_BQ_NUM];    // input delay two
  logic signed [SW-1:0] bq_y1_q [`RBM_BQ_NUM];    // output delay one
  logic signed [SW-1:0] bq_y2_q [`RBM_BQ_NUM];    // output delay two
  logic               lp_phase_q;                 // low-power sample skip
  logic               take;                       // input sample is accumulated
  logic signed [63:0] mix_acc_q;                  // mixer running sum
  logic signed [63:0] mix_next;                   // mixer sum with this term
  logic signed [31:0] mix_coef;                   // current mixer factor

  // engine
  rbm_pkg::rbm_state_t state_q;                   // sequencing state
  logic [3:0]         step_q;                     // step within state
  logic               start_q;                    // decimated frame ready
  logic [3:0]         cb;                         // coefficient biquad index
  logic               bq_active;                  // current biquad in use
  logic signed [SW-1:0] bq_y;                     // current biquad output

  // fifo and output stage
  logic               fifo_in_valid;              // engine offers a sample
  logic               fifo_in_ready;              // fifo room
  rbm_pkg::rbm_sample_t fifo_in_data;             // sample into fifo
  logic               fifo_out_valid;             // fifo has a sample
  rbm_pkg::rbm_sample_t fifo_out_data;            // fifo head
  logic               fifo_pop;                   // head moves to output stage
  logic [2:0]         fifo_level;                 // fifo fill
  logic               out_valid_q;                // output stage full
  rbm_pkg::rbm_sample_t out_sample_q;             // output stage data

  // saturate a wide value to the sample width
  function automatic logic signed [SW-1:0] sat(input logic signed [63:0] v);
    logic signed [63:0] hi;
    logic signed [63:0] lo;
    hi = 64'(signed'({1'b0, {(SW-1){1'b1}}}));
    lo = -hi - 64'sd1;
    if (v > hi) begin
      sat = {1'b0, {(SW-1){1'b1}}};
    end else if (v < lo) begin
      sat = {1'b1, {(SW-1){1'b0}}};
    end else begin
      sat = v[SW-1:0];
    end
  endfunction

  // big-endian coefficient word k of biquad bi
  function automatic logic signed [31:0] bq_coef(input logic [3:0] bi, input logic [2:0] k);
    logic [7:0] b;
    b = 8'(bi * `RBM_BQ_BYTES) + 8'({k, 2'b00});
    bq_coef = {bq_mem_q[b], bq_mem_q[b+8'd1], bq_mem_q[b+8'd2], bq_mem_q[b+8'd3]};
  endfunction

  // field views
  assign alloc     = dsp_cfg_q[`RBM_BQ_HI:`RBM_BQ_LO];
  assign deci_type = rbm_pkg::rbm_deci_t'(dsp_cfg_q[`RBM_DECI_HI:`RBM_DECI_LO]);
  assign low_power = lp_cfg_q[`RBM_LP_BIT];
  assign bank_sel  = ctrl_q[`RBM_CTRL_BANK];
  assign two_ch    = ctrl_q[`RBM_CTRL_TWO_CH];
  assign sum_mode  = ctrl_q[`RBM_CTRL_SUM];
  assign pdm_sel   = ctrl_q[`RBM_CTRL_PDM_LO+3:`RBM_CTRL_PDM_LO];

  assign bq_hit  = (ctl.page == `RBM_PAGE_BQ_LO || ctl.page == `RBM_PAGE_BQ_HI) && ctl.addr >= `RBM_BQ_BASE;
  assign bq_idx  = ((ctl.page == `RBM_PAGE_BQ_HI) ? `RBM_BQ_PAGE_BYTES : 8'h00) + 8'(ctl.addr - `RBM_BQ_BASE);
  assign mix_hit = (ctl.page == `RBM_PAGE_MIX) && ctl.addr >= `RBM_MIX_BASE && ctl.addr < `RBM_MIX_END;
  assign mix_idx = 6'(ctl.addr - `RBM_MIX_BASE);

  // configuration register writes
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      // allocation resets to two per channel
      dsp_cfg_q <= `RBM_DSP_CFG_RST;
      lp_cfg_q  <= `RBM_LP_CFG_RST;
      ctrl_q    <= `RBM_CTRL_RST;
    end else if (ctl.wr && ctl.page == `RBM_PAGE_CFG) begin
      if (ctl.addr == `RBM_REG_DSP_CFG) begin
        dsp_cfg_q <= ctl.wdata;
      end
      if (ctl.addr == `RBM_REG_LP_CFG) begin
        lp_cfg_q <= ctl.wdata;
      end
      if (ctl.addr == `RBM_REG_CTRL) begin
        ctrl_q <= ctl.wdata;
      end
    end
  end

  // biquad coefficient bytes, one per entry
  for (genvar gi = 0; gi < `RBM_BQ_TOTAL; gi++) begin : g_bq_byte
    localparam int POS = gi % `RBM_BQ_BYTES;
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        // numerator zero at one, rest zero
        bq_mem_q[gi] <= (POS < 4) ? 8'(`RBM_COEF_ONE >> (8 * (3 - POS))) : 8'h00;
      end else if (ctl.wr && bq_hit && bq_idx == 8'(gi)) begin
        bq_mem_q[gi] <= ctl.wdata;
      end
    end
  end

  // mixer coefficient bytes, identity by default
  for (genvar gm = 0; gm < `RBM_MIX_TOTAL; gm++) begin : g_mix_byte
    localparam int WORD = gm / 4;
    localparam int POS  = gm % 4;
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        mix_mem_q[gm] <= (WORD / 4 == WORD % 4) ? 8'(`RBM_COEF_ONE >> (8 * (3 - POS))) : 8'h00;
      end else if (ctl.wr && mix_hit && mix_idx == 6'(gm)) begin
        mix_mem_q[gm] <= ctl.wdata;
      end
    end
  end

  // overrun flag, a new frame wins over the clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      overrun_q <= 1'b0;
    end else if (start_q && state_q != rbm_pkg::RBM_ST_IDLE) begin
      overrun_q <= 1'b1;
    end else if (ctl.wr && ctl.page == `RBM_PAGE_CFG && ctl.addr == `RBM_REG_STATUS
                 && ctl.wdata[`RBM_STAT_OVERRUN]) begin
      overrun_q <= 1'b0;
    end
  end

  // control port read data
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctl_rdata_q <= 8'h00;
    end else if (ctl.rd) begin
      if (ctl.page == `RBM_PAGE_CFG && ctl.addr == `RBM_REG_DSP_CFG) begin
        ctl_rdata_q <= dsp_cfg_q;
      end else if (ctl.page == `RBM_PAGE_CFG && ctl.addr == `RBM_REG_LP_CFG) begin
        ctl_rdata_q <= lp_cfg_q;
      end else if (ctl.page == `RBM_PAGE_CFG && ctl.addr == `RBM_REG_CTRL) begin
        ctl_rdata_q <= ctrl_q;
      end else if (ctl.page == `RBM_PAGE_CFG && ctl.addr == `RBM_REG_STATUS) begin
        // live engine state
        ctl_rdata_q <= {fifo_level, 2'b00, bank_sel & two_ch, overrun_q,
                        state_q != rbm_pkg::RBM_ST_IDLE};
      end else if (bq_hit) begin
        ctl_rdata_q <= bq_mem_q[bq_idx];
      end else if (mix_hit) begin
        ctl_rdata_q <= mix_mem_q[mix_idx];
      end else begin
        // unmapped reads as zero
        ctl_rdata_q <= 8'h00;
      end
    end
  end

  // low-power mode keeps every second input
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lp_phase_q <= 1'b0;
    end else if (mod_in.valid) begin
      lp_phase_q <= ~lp_phase_q;
    end
  end
  assign take = mod_in.valid && (!low_power || lp_phase_q);

  // decimation, one accumulator per channel
  for (genvar gc = 0; gc < `RBM_NUM_CH; gc++) begin : g_deci
    logic signed [7:0]  smp;                      // this input sample
    logic signed [33:0] dec_w;                    // decimated value before clip
    // microphone bit maps to full scale
    assign smp = pdm_sel[gc] ? (mod_in.pdm[gc] ? `RBM_PDM_POS : `RBM_PDM_NEG)
                             : mod_in.multibit[gc*8 +: 8];
    // type field and low-power bit choose
    always_comb begin
      if (low_power) begin
        dec_w = 34'(acc_q[gc]) <<< 1;
      end else begin
        unique case (deci_type)
          rbm_pkg::RBM_DECI_LOW:   dec_w = (34'(acc_q[gc]) * 34'sd3 + 34'(prev_q[gc])) >>> 2;
          rbm_pkg::RBM_DECI_ULTRA: dec_w = 34'(acc_q[gc]);
          // reserved acts as linear phase
          default:                 dec_w = (34'(acc_q[gc]) + 34'(prev_q[gc])) >>> 1;
        endcase
      end
    end
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        acc_q[gc]  <= '0;
        prev_q[gc] <= '0;
        dec_q[gc]  <= '0;
      end else if (frame_sync) begin
        dec_q[gc]  <= sat(64'(dec_w));
        prev_q[gc] <= acc_q[gc];
        acc_q[gc]  <= take ? 32'(smp) : '0;
      end else if (take) begin
        acc_q[gc] <= acc_q[gc] + 32'(smp);
      end
    end
  end

  // frame handed to the engine one cycle after sync
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      start_q <= 1'b0;
    end else begin
      start_q <= frame_sync;
    end
  end

  // summing mode uses one quarter each
  assign mix_coef = sum_mode ? `RBM_COEF_QUARTER
                             : {mix_mem_q[{step_q, 2'b00}], mix_mem_q[{step_q, 2'b01}],
                                mix_mem_q[{step_q, 2'b10}], mix_mem_q[{step_q, 2'b11}]};
  // fraction product scaled back by 2^31
  assign mix_next = ((step_q[1:0] == 2'b00) ? 64'sd0 : mix_acc_q) + 64'(dec_q[step_q[1:0]]) * 64'(mix_coef);

  // second bank is the idle pair's sections
  assign cb = (two_ch && bank_sel && !step_q[1]) ? step_q + `RBM_BANK_OFFSET : step_q;
  // zero allocation leaves every section idle
  // stage index step/4 below allocation count
  assign bq_active = (state_q == rbm_pkg::RBM_ST_BQ) && (step_q[3:2] < alloc);

  always_comb begin
    logic signed [63:0] t0;
    logic signed [63:0] t1;
    logic signed [63:0] t2;
    logic signed [63:0] t3;
    logic signed [63:0] t4;
    t0 = 64'(bq_coef(cb, 3'd0)) * 64'(chan_q[step_q[1:0]]);
    t1 = 64'(bq_coef(cb, 3'd1)) * 64'(bq_x1_q[step_q]);
    t2 = 64'(bq_coef(cb, 3'd2)) * 64'(bq_x2_q[step_q]);
    t3 = 64'(bq_coef(cb, 3'd3)) * 64'(bq_y1_q[step_q]);
    t4 = 64'(bq_coef(cb, 3'd4)) * 64'(bq_y2_q[step_q]);
    bq_y = sat((t0 + (t1 <<< 1) + t2 + (t3 <<< 1) + t4 + `RBM_FRAC_ROUND) >>> `RBM_FRAC_SHIFT);
  end

  for (genvar gb = 0; gb < `RBM_BQ_NUM; gb++) begin : g_bq_hist
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        bq_x1_q[gb] <= '0;
        bq_x2_q[gb] <= '0;
        bq_y1_q[gb] <= '0;
        bq_y2_q[gb] <= '0;
      end else if (bq_active && step_q == 4'(gb)) begin
        bq_x1_q[gb] <= chan_q[step_q[1:0]];
        bq_x2_q[gb] <= bq_x1_q[gb];
        bq_y1_q[gb] <= bq_y;
        bq_y2_q[gb] <= bq_y1_q[gb];
      end
    end
  end

  // mixer running sum
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mix_acc_q <= '0;
    end else if (state_q == rbm_pkg::RBM_ST_MIX) begin
      mix_acc_q <= mix_next;
    end
  end

  // channel samples: mixer result, then each biquad in place
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int c = 0; c < `RBM_NUM_CH; c++) begin
        chan_q[c] <= '0;
      end
    end else if (state_q == rbm_pkg::RBM_ST_MIX && step_q[1:0] == 2'b11) begin
      chan_q[step_q[3:2]] <= sat((mix_next + `RBM_FRAC_ROUND) >>> `RBM_FRAC_SHIFT);
    end else if (bq_active) begin
      chan_q[step_q[1:0]] <= bq_y;
    end
  end

  // engine sequencing
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= rbm_pkg::RBM_ST_IDLE;
      step_q  <= 4'h0;
    end else begin
      unique case (state_q)
        rbm_pkg::RBM_ST_IDLE: begin
          if (start_q) begin
            state_q <= rbm_pkg::RBM_ST_MIX;
            step_q  <= 4'h0;
          end
        end
        rbm_pkg::RBM_ST_MIX: begin
          // sixteen products, output then input
          step_q <= step_q + 4'h1;
          if (step_q == 4'hF) begin
            state_q <= rbm_pkg::RBM_ST_BQ;
          end
        end
        rbm_pkg::RBM_ST_BQ: begin
          // twelve section slots, idle ones pass
          if (step_q == 4'(`RBM_BQ_NUM - 1)) begin
            state_q <= rbm_pkg::RBM_ST_PUSH;
            step_q  <= 4'h0;
          end else begin
            step_q <= step_q + 4'h1;
          end
        end
        rbm_pkg::RBM_ST_PUSH: begin
          // stalls while the fifo is full
          if (fifo_in_ready) begin
            if (step_q == 4'(`RBM_NUM_CH - 1)) begin
              state_q <= rbm_pkg::RBM_ST_IDLE;
              step_q  <= 4'h0;
            end else begin
              step_q <= step_q + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // samples into the fifo in channel order
  assign fifo_in_valid = (state_q == rbm_pkg::RBM_ST_PUSH);
  assign fifo_in_data  = '{ch: step_q[1:0], data: chan_q[step_q[1:0]]};

  rbm_fifo #(
    .WIDTH ($bits(rbm_pkg::rbm_sample_t)),
    .DEPTH (`RBM_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (fifo_in_valid),
    .in_data   (fifo_in_data),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (fifo_pop),
    .level     (fifo_level)
  );

  // registered output stage
  assign fifo_pop = fifo_out_valid && (!out_valid_q || out_ready);
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      out_valid_q  <= 1'b0;
      out_sample_q <= '0;
    end else if (!out_valid_q || out_ready) begin
      out_valid_q  <= fifo_out_valid;
      out_sample_q <= fifo_out_data;
    end
  end

  assign out_valid  = out_valid_q;
  assign out_sample = out_sample_q;
  assign ctl_rdata  = ctl_rdata_q;
endmodule

// ==== verif/rbm_record_dsp_properties.sv ====
// port assertions for the record dsp block
`timescale 1ns/100ps
module rbm_chk (
  input wire logic                  clk,        // core clock
  input wire logic                  reset_n,    // sync reset, active low
  input wire rbm_pkg::rbm_ctl_req_t ctl,        // control request
  input wire logic [7:0]            ctl_rdata,  // read byte
  input wire rbm_pkg::rbm_mod_in_t  mod_in,     // modulator input
  input wire logic                  frame_sync, // frame pulse
  input wire logic                  out_valid,  // sample present
  input wire rbm_pkg::rbm_sample_t  out_sample, // sample and channel
  input wire logic                  out_ready   // sink takes sample
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic cfg_wr_q;                                           // config written since reset
  wire  cfg_hit = ctl.page == 8'h00 && ctl.addr == 7'h72;   // config register addressed
  // remembers a config write since reset
  always_ff @(posedge clk) begin
    if (!reset_n) cfg_wr_q <= 1'b0;
    else if (ctl.wr && cfg_hit) cfg_wr_q <= 1'b1;
  end
  a_reset_quiet: assert property (disable iff (1'b0) !reset_n |=> !out_valid && ctl_rdata == 8'h00)
    else $error("outputs not cleared in reset");
  a_cfg_default: assert property (ctl.rd && cfg_hit && !cfg_wr_q |=> ctl_rdata == 8'h08)
    else $error("config reset value wrong");
  a_cfg_readback: assert property (ctl.wr && cfg_hit ##2 ctl.rd && cfg_hit |=> ctl_rdata == $past(ctl.wdata, 3))
    else $error("config readback wrong");
  a_lp_bit: assert property (ctl.wr && ctl.page == 8'h00 && ctl.addr == 7'h4E ##2 ctl.rd
    && ctl.page == 8'h00 && ctl.addr == 7'h4E |=> ctl_rdata[2] == $past(ctl.wdata[2], 3))
    else $error("low power bit readback wrong");
  a_unmapped_zero: assert property (ctl.rd && ctl.page == 8'h05 |=> ctl_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!ctl.rd |=> $stable(ctl_rdata))
    else $error("read byte moved without read");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_sample))
    else $error("stalled sample not held");
  a_chan_order: assert property (out_valid && out_ready |=> !out_valid || out_sample.ch == $past(out_sample.ch) + 2'h1)
    else $error("channel order broken");
  c_frame: cover property (frame_sync);
  c_stall: cover property (out_valid && !out_ready);
  c_last_ch: cover property (out_valid && out_ready && out_sample.ch == 2'h3);
endmodule
bind rbm_record_dsp rbm_chk u_chk (.clk(clk), .reset_n(reset_n), .ctl(ctl), .ctl_rdata(ctl_rdata), .mod_in(mod_in),
  .frame_sync(frame_sync), .out_valid(out_valid), .out_sample(out_sample), .out_ready(out_ready));

// ==== verif/rbm_host_model.sv ====
// host model driving the byte control port
`timescale 1ns/100ps
module rbm_host_model (
  input wire logic              clk,       // core clock
  output rbm_pkg::rbm_ctl_req_t ctl,       // control request
  input wire logic [7:0]        ctl_rdata  // read byte
);
  initial ctl = '0;
  // one access, released lines show inverted old value
  task automatic acc(input logic w, input logic [7:0] pg, input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    #2 ctl = {w, ~w, pg, a, d};
    @(posedge clk);
    #2 ctl = {2'b00, ~ctl[22:0]};
  endtask
  // read byte lands one cycle after the taking edge
  task automatic rd(input logic [7:0] pg, input logic [6:0] a, output logic [7:0] d);
    acc(1'b0, pg, a, 8'h00);
    @(posedge clk);
    d = ctl_rdata;
  endtask
  // coefficient written most significant byte first
  task automatic wr32(input logic [7:0] pg, input logic [6:0] a, input logic [31:0] v);
    for (int i = 0; i < 4; i++) acc(1'b1, pg, a + 7'(i), v[31-8*i -: 8]);
  endtask
endmodule

// ==== verif/tb_rbm_record_dsp.sv ====
// self-checking bench for the record dsp block
`timescale 1ns/100ps
module tb_rbm_record_dsp;
  logic                  clk, reset_n, frame_sync, out_ready, out_valid; // clock and stream controls
  logic [7:0]            ctl_rdata, rb;                                  // read byte, readback
  logic [23:0]           ex [4];                                         // expected samples
  rbm_pkg::rbm_ctl_req_t ctl;                                            // control request
  rbm_pkg::rbm_mod_in_t  mod_in;                                         // modulator input
  rbm_pkg::rbm_sample_t  out_sample;                                     // output sample
  int                    fails = 0, samples_checked = 0, cyc = 0;        // counters
  localparam logic [31:0] V = 32'h040CFC08;                              // ch0 8, ch1 -4, ch2 12, ch3 4
  rbm_host_model u_host (.clk(clk), .ctl(ctl), .ctl_rdata(ctl_rdata));
  rbm_record_dsp u_dut (.clk(clk), .reset_n(reset_n), .ctl(ctl), .ctl_rdata(ctl_rdata), .mod_in(mod_in),
    .frame_sync(frame_sync), .out_valid(out_valid), .out_sample(out_sample), .out_ready(out_ready));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // cycle ceiling against hangs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk24(string n, logic [23:0] e, logic [23:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rdchk(logic [7:0] pg, logic [6:0] a, logic [7:0] e);
    u_host.rd(pg, a, rb);
    chk8("reg", e, rb);
  endtask
  // one input word then the closing frame pulse
  task automatic frm();
    @(posedge clk);
    #2 mod_in = {1'b1, 4'hF, V};
    @(posedge clk);
    #2 mod_in.valid = 1'b0;
    frame_sync = 1'b1;
    @(posedge clk);
    #2 frame_sync = 1'b0;
  endtask
  // settle a frame, then check the next one, optionally stalled
  task automatic run(bit st);
    int w;
    frm();
    repeat (45) @(posedge clk);
    frm();
    out_ready = !st;
    repeat (st ? 60 : 0) @(posedge clk);
    #2 out_ready = 1'b1;
    for (int c = 0; c < 4; c++) begin
      w = 0;
      do begin
        @(posedge clk);
        w++;
      end while (!(out_valid === 1'b1 && out_ready === 1'b1) && w < 200);
      chk8("ch", 8'(c), {6'h00, out_sample.ch});
      chk24("data", ex[c], out_sample.data);
    end
  endtask
  // reset, then scenarios as call sequences
  initial begin
    reset_n = 1'b0;
    frame_sync = 1'b0;
    out_ready = 1'b1;
    mod_in = '0;
    repeat (10) @(posedge clk);
    #2 reset_n = 1'b1;
    rdchk(8'h00, 7'h72, 8'h08);
    rdchk(8'h00, 7'h4E, 8'h00);
    rdchk(8'h08, 7'h0B, 8'hFF);
    rdchk(8'h05, 7'h10, 8'h00);
    // defaults pass samples unchanged
    ex = '{24'h000008, 24'hFFFFFC, 24'h00000C, 24'h000004};
    run(1'b0);
    rdchk(8'h00, 7'h74, 8'h00);
    u_host.acc(1'b1, 8'h00, 7'h73, 8'h04);
    ex = '{4{24'h000005}};
    run(1'b1);
    // half gain section 0, half input 0 into mixer 1
    u_host.acc(1'b1, 8'h00, 7'h73, 8'h00);
    u_host.wr32(8'h08, 7'h08, 32'h40000000);
    u_host.wr32(8'h0C, 7'h18, 32'h40000000);
    rdchk(8'h08, 7'h08, 8'h40);
    ex = '{24'h000004, 24'h000000, 24'h00000C, 24'h000004};
    run(1'b0);
    // bypass, low-power doubles
    u_host.acc(1'b1, 8'h00, 7'h72, 8'h00);
    rdchk(8'h00, 7'h72, 8'h00);
    u_host.acc(1'b1, 8'h00, 7'h4E, 8'h04);
    rdchk(8'h00, 7'h4E, 8'h04);
    ex = '{24'h000010, 24'h000000, 24'h000018, 24'h000008};
    run(1'b0);
    // microphone bits at full scale
    u_host.acc(1'b1, 8'h00, 7'h4E, 8'h00);
    u_host.acc(1'b1, 8'h00, 7'h73, 8'hF0);
    ex = '{24'h00007F, 24'h0000BE, 24'h00007F, 24'h00007F};
    run(1'b0);
    // second reset restores defaults
    #2 reset_n = 1'b0;
    repeat (3) @(posedge clk);
    #2 reset_n = 1'b1;
    rdchk(8'h00, 7'h72, 8'h08);
    rdchk(8'h08, 7'h08, 8'h7F);
    end_of_test();
  end
  task automatic end_of_test();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
endmodule
